// ===== fbc_flash_model.sv
/*
 fbc_flash_model: behavioural byte-wide flash device on the host pins.
 assumes sys_clk only paces internal jobs; the bench resolves the data bus.
*/
`timescale 1ns/1ps
module fbc_flash_model #(
    // identity values are arbitrary
    parameter logic [7:0] MAKER_CODE = 8'h3C,
    parameter logic [7:0] PART_CODE = 8'hC5,
    parameter int ERASE_CYC = 300,
    parameter int WRITE_CYC = 40
) (
    input wire logic sys_clk,
    input wire logic reset_powerdown_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [19:0] addr,
    input wire logic [7:0] dq_in,
    input wire logic vpp_high,
    output logic [7:0] dq_out,
    output logic dq_drive,
    output logic ready_busy_out
);
    logic [1:0] mode;
    logic [1:0] pend;
    logic [6:0] st;
    logic [3:0] blk;
    logic ejob;
    logic susp;
    logic [15:0] erased;
    int busy_cnt;
    logic [7:0] mem [logic [19:0]];
    initial begin
        mode = 0; pend = 0; st = 0; busy_cnt = 0; erased = 0; ejob = 0; susp = 0;
    end
    always @(negedge reset_powerdown_n) begin
        mode = 0; pend = 0; st = 0; busy_cnt = 0; susp = 0;
    end
    always @(posedge sys_clk) begin
        if (reset_powerdown_n && busy_cnt > 0 && !susp) begin
            busy_cnt = busy_cnt - 1;
            if (busy_cnt == 0 && ejob) erased[blk] = 1'b1;
        end
    end
    always @(posedge we_n) begin
        if (reset_powerdown_n && !ce_n) begin
            if (pend == 1) begin
                pend = 0; mode = 2;
                if (dq_in == 8'hD0 && vpp_high) begin
                    blk = addr[19:16]; ejob = 1; busy_cnt = ERASE_CYC;
                end else if (dq_in == 8'hD0) st[3] = 1'b1;
            end else if (pend == 2) begin
                pend = 0; mode = 2;
                if (vpp_high) begin
                    mem[addr] = dq_in; ejob = 0; busy_cnt = WRITE_CYC;
                end else st[3] = 1'b1;
            end else if (busy_cnt > 0 && !susp) begin
                if (dq_in == 8'h70) mode = 2;
                else if (dq_in == 8'hB0 && ejob) begin
                    susp = 1; mode = 2;
                end
            end else begin
                case (dq_in)
                    8'hFF: mode = 0;
                    8'h90: mode = 1;
                    8'h70: mode = 2;
                    8'h50: st[5:3] = 3'h0;
                    8'h20: pend = 1;
                    8'h40, 8'h10: pend = 2;
                    8'hD0: if (susp) begin
                        susp = 0; mode = 2;
                    end
                    default: ;
                endcase
            end
        end
    end
    // drive only when selected and enabled
    assign dq_drive = reset_powerdown_n && !ce_n && !oe_n;
    assign ready_busy_out = (busy_cnt == 0) || susp;
    always_comb begin
        if (mode == 1) dq_out = addr[0] ? PART_CODE : MAKER_CODE;
        else if (mode == 2) dq_out = {ready_busy_out, st};
        else if (mem.exists(addr)) dq_out = mem[addr];
        else if (erased[addr[19:16]]) dq_out = 8'hFF;
        else dq_out = addr[7:0] ^ addr[15:8];
    end
endmodule

// ===== fbc_host.sv
/*
 fbc_host: host controller driving a byte-wide block-erasable flash.
 assumes the flash pins connect directly; dq input comes from the pad.
*/
// Contract
// - read: select, output enable, others high
// - wait output-valid interval after wake
// - wait write interval after wake
// - id read: addr 0 maker, 1 part
// - command write: we low, ce low
// - erase cycles carry block address
// - byte write: setup then data, same address
// - three read modes chosen by command
// - array read command after job
// - ff selects array read
// - 70 selects status read
// - erase is 20 then d0
`timescale 1ns/1ps
module fbc_host (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic powerdown_req,
    input wire logic req_valid,
    output logic req_ready,
    input wire fbc_pkg::fbc_req_t req,
    output logic resp_valid,
    output logic [7:0] resp_data,
    output logic reset_powerdown_n,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [19:0] addr,
    input wire logic [7:0] data_pins_in,
    output logic [7:0] data_pins_out,
    output logic data_pins_oe,
    input wire logic ready_busy_out,
    output logic flash_busy
);
    typedef enum logic [2:0] {S_SLEEP, S_WAKE, S_IDLE, S_CYC1, S_CYC2, S_FIN} fbc_state_t;
    fbc_state_t state_reg, state_next;
    logic [6:0] wait_reg, wait_next;
    fbc_pkg::fbc_req_t cur_reg, cur_next;
    logic [7:0] dq_s1_reg, dq_s2_reg;
    logic rb_s1_reg, rb_s2_reg;
    logic rp_reg, rp_next;
    logic rv_reg, rv_next;
    logic [7:0] rd_reg, rd_next;
    logic st_start, st_write, st_done;
    logic [19:0] st_addr;
    logic [7:0] st_wdata, st_rdata;
    fbc_pkg::fbc_pins_t pins;

    // first code of each operation
    function automatic logic [7:0] first_code(input fbc_pkg::fbc_op_t op);
        case (op)
            fbc_pkg::FBC_OP_READ_ID: first_code = fbc_pkg::CMD_READ_ID;
            fbc_pkg::FBC_OP_READ_STATUS: first_code = fbc_pkg::CMD_READ_STATUS;
            fbc_pkg::FBC_OP_CLEAR_STATUS: first_code = fbc_pkg::CMD_CLEAR_STATUS;
            fbc_pkg::FBC_OP_ERASE: first_code = fbc_pkg::CMD_ERASE_SETUP;
            fbc_pkg::FBC_OP_BYTE_WRITE: first_code = fbc_pkg::CMD_WRITE_SETUP;
            fbc_pkg::FBC_OP_SUSPEND: first_code = fbc_pkg::CMD_SUSPEND;
            fbc_pkg::FBC_OP_RESUME: first_code = fbc_pkg::CMD_CONFIRM;
            default: first_code = fbc_pkg::CMD_READ_ARRAY;
        endcase
    endfunction

    // operations ending with a read cycle
    function automatic logic ends_in_read(input fbc_pkg::fbc_op_t op);
        ends_in_read = (op == fbc_pkg::FBC_OP_READ) || (op == fbc_pkg::FBC_OP_READ_ID)
            || (op == fbc_pkg::FBC_OP_READ_STATUS);
    endfunction

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dq_s1_reg <= fbc_pkg::DATA_RESET;
            dq_s2_reg <= fbc_pkg::DATA_RESET;
            rb_s1_reg <= 1'b1;
            rb_s2_reg <= 1'b1;
        end else if (clk_en) begin
            dq_s1_reg <= data_pins_in;
            dq_s2_reg <= dq_s1_reg;
            rb_s1_reg <= ready_busy_out;
            rb_s2_reg <= rb_s1_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        wait_next = wait_reg;
        cur_next = cur_reg;
        rp_next = rp_reg;
        rv_next = 1'b0;
        rd_next = rd_reg;
        st_start = 1'b0;
        st_write = 1'b1;
        st_addr = cur_reg.addr;
        st_wdata = first_code(cur_reg.op);
        case (state_reg)
            S_SLEEP: begin
                rp_next = 1'b0;
                if (!powerdown_req) begin
                    rp_next = 1'b1;
                    state_next = S_WAKE;
                    wait_next = 7'(fbc_pkg::WAKE_WRITE_CYC);
                end
            end
            S_WAKE: begin
                if (wait_reg == 7'h00) begin
                    state_next = S_IDLE;
                end else begin
                    wait_next = wait_reg - 7'h01;
                end
            end
            S_IDLE: begin
                if (powerdown_req) begin
                    state_next = S_SLEEP;
                    rp_next = 1'b0;
                end else if (req_valid) begin
                    cur_next = req;
                    state_next = S_CYC1;
                end
            end
            S_CYC1: begin
                st_start = 1'b1;
                state_next = S_FIN;
            end
            S_FIN: begin
                if (st_done) begin
                    state_next = (cur_reg.op == fbc_pkg::FBC_OP_CLEAR_STATUS
                        || cur_reg.op == fbc_pkg::FBC_OP_SUSPEND
                        || cur_reg.op == fbc_pkg::FBC_OP_RESUME) ? S_IDLE : S_CYC2;
                    if (state_next == S_IDLE) begin
                        rv_next = 1'b1;
                    end
                end
            end
            S_CYC2: begin
                st_start = 1'b1;
                st_write = !ends_in_read(cur_reg.op);
                st_wdata = (cur_reg.op == fbc_pkg::FBC_OP_ERASE) ? fbc_pkg::CMD_CONFIRM
                    : cur_reg.data;
                state_next = S_FIN;
                cur_next.op = ends_in_read(cur_reg.op) ? cur_reg.op : fbc_pkg::FBC_OP_RESUME;
            end
            default: state_next = S_IDLE;
        endcase
        if (state_reg == S_FIN && st_done && ends_in_read(cur_reg.op) && wait_reg == 7'h01) begin
            state_next = S_IDLE;
        end
        if (state_reg == S_CYC2) begin
            wait_next = 7'h01;
        end else if (state_reg == S_CYC1) begin
            wait_next = 7'h00;
        end
        if (state_reg == S_FIN && st_done && wait_reg == 7'h01 && ends_in_read(cur_reg.op)) begin
            rv_next = 1'b1;
            rd_next = st_rdata;
            wait_next = 7'h00;
        end else if (state_reg == S_FIN && st_done && wait_reg == 7'h01) begin
            state_next = S_IDLE;
            rv_next = 1'b1;
            wait_next = 7'h00;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= S_SLEEP;
            wait_reg <= 7'h00;
            cur_reg <= '0;
            rp_reg <= 1'b0;
            rv_reg <= 1'b0;
            rd_reg <= fbc_pkg::DATA_RESET;
        end else if (clk_en) begin
            state_reg <= state_next;
            wait_reg <= wait_next;
            cur_reg <= cur_next;
            rp_reg <= rp_next;
            rv_reg <= rv_next;
            rd_reg <= rd_next;
        end
    end

    fbc_strobe u_strobe (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .start(st_start),
        .is_write(st_write),
        .addr(st_addr),
        .wdata(st_wdata),
        .dq_in_sync(dq_s2_reg),
        .done(st_done),
        .rdata(st_rdata),
        .pins(pins),
        .dq_out(data_pins_out),
        .dq_oe(data_pins_oe)
    );

    assign req_ready = (state_reg == S_IDLE) && !powerdown_req;
    assign resp_valid = rv_reg;
    assign resp_data = rd_reg;
    assign reset_powerdown_n = rp_reg;
    assign ce_n = pins.ce_n || !rp_reg;
    assign oe_n = pins.oe_n || !rp_reg;
    assign we_n = pins.we_n || !rp_reg;
    assign addr = pins.addr;
    assign flash_busy = !rb_s2_reg;

    property p_wake_wait;
        @(posedge sys_clk) disable iff (!nrst)
        (clk_en && state_reg == S_SLEEP && !powerdown_req) |=> state_reg == S_WAKE;
    endproperty
    a_wake_wait: assert property (p_wake_wait) else $error("no wake wait");

    property p_write_sel;
        @(posedge sys_clk) disable iff (!nrst)
        !we_n |-> (!ce_n && oe_n && reset_powerdown_n);
    endproperty
    a_write_sel: assert property (p_write_sel) else $error("write without select");

    property p_read_pins;
        @(posedge sys_clk) disable iff (!nrst)
        !oe_n |-> (!ce_n && we_n && reset_powerdown_n && !data_pins_oe);
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("bad read pins");

    property p_sleep_idle;
        @(posedge sys_clk) disable iff (!nrst)
        !reset_powerdown_n |-> (ce_n && we_n && oe_n);
    endproperty
    a_sleep_idle: assert property (p_sleep_idle) else $error("strobe in sleep");

    property p_write_hold;
        @(posedge sys_clk) disable iff (!nrst)
        (!we_n && !$past(we_n)) |-> (data_pins_oe && $stable(addr) && $stable(data_pins_out));
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("write inputs moved");

    property p_wake_no_write;
        @(posedge sys_clk) disable iff (!nrst)
        (state_reg == S_WAKE) |-> (we_n && ce_n);
    endproperty
    a_wake_no_write: assert property (p_wake_no_write) else $error("write while waking");
endmodule

// ===== fbc_pkg.sv
/*
 fbc_pkg: constants and types for the flash bus host controller.
 assumes a 100 MHz sys_clk; all counts are in sys_clk cycles.
*/
package fbc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // wake intervals, as printed
    localparam int WAKE_TO_OUTPUT_VALID_NS = 400;
    localparam int WAKE_TO_WRITE_NS = 1000;
    localparam int WAKE_READ_CYC = (WAKE_TO_OUTPUT_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_WRITE_CYC = (WAKE_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // strobe timing in cycles (plain defaults)
    localparam logic [3:0] READ_CYC = 4'h9;
    localparam logic [3:0] WRITE_LOW_CYC = 4'h6;
    localparam logic [3:0] WRITE_HIGH_CYC = 4'h3;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
    localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
    localparam logic [19:0] ID_MAKER_ADDR = 20'h0_0000;
    localparam logic [19:0] ID_PART_ADDR = 20'h0_0001;
    localparam logic [19:0] ADDR_RESET = 20'h0_0000;
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef enum logic [2:0] {
        FBC_OP_READ,
        FBC_OP_READ_ID,
        FBC_OP_READ_STATUS,
        FBC_OP_CLEAR_STATUS,
        FBC_OP_ERASE,
        FBC_OP_BYTE_WRITE,
        FBC_OP_SUSPEND,
        FBC_OP_RESUME
    } fbc_op_t;

    typedef struct packed {
        fbc_op_t op;
        logic [19:0] addr;
        logic [7:0] data;
    } fbc_req_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [19:0] addr;
    } fbc_pins_t;
endpackage

// ===== fbc_strobe.sv
/*
 fbc_strobe: one bus cycle (read or command write) on the flash pins.
 assumes pins settle within the cycle counts of fbc_pkg.
*/
`timescale 1ns/1ps
module fbc_strobe (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic is_write,
    input wire logic [19:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] dq_in_sync,
    output logic done,
    output logic [7:0] rdata,
    output fbc_pkg::fbc_pins_t pins,
    output logic [7:0] dq_out,
    output logic dq_oe
);
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} fbc_st_t;
    fbc_st_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic wr_reg, wr_next;
    logic [19:0] addr_reg, addr_next;
    logic [7:0] wd_reg, wd_next, rd_reg, rd_next;

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        addr_next = addr_reg;
        wd_next = wd_reg;
        rd_next = rd_reg;
        case (st_reg)
            ST_IDLE: begin
                if (start) begin
                    st_next = ST_LOW;
                    wr_next = is_write;
                    addr_next = addr;
                    wd_next = wdata;
                    cnt_next = is_write ? fbc_pkg::WRITE_LOW_CYC : fbc_pkg::READ_CYC;
                end
            end
            ST_LOW: begin
                if (cnt_reg == 4'h0) begin
                    // sample read data at end of strobe
                    if (!wr_reg) begin
                        rd_next = dq_in_sync;
                    end
                    st_next = ST_HIGH;
                    cnt_next = fbc_pkg::WRITE_HIGH_CYC;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            ST_HIGH: begin
                if (cnt_reg == 4'h0) begin
                    st_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            wr_reg <= 1'b0;
            addr_reg <= fbc_pkg::ADDR_RESET;
            wd_reg <= fbc_pkg::DATA_RESET;
            rd_reg <= fbc_pkg::DATA_RESET;
        end else if (clk_en) begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            addr_reg <= addr_next;
            wd_reg <= wd_next;
            rd_reg <= rd_next;
        end
    end

    assign pins.ce_n = !((st_reg == ST_LOW) || ((st_reg == ST_HIGH) && wr_reg));
    assign pins.oe_n = !((st_reg == ST_LOW) && !wr_reg);
    assign pins.we_n = !((st_reg == ST_LOW) && wr_reg);
    assign pins.addr = addr_reg;
    assign dq_out = wd_reg;
    assign dq_oe = wr_reg && (st_reg != ST_IDLE);
    assign rdata = rd_reg;
    assign done = (st_reg == ST_HIGH) && (cnt_reg == 4'h0);
endmodule

// ===== flash_bus_command_interface_tb_top.sv
/*
 bench for fbc_host against the flash model.
 assumes 100 MHz sys_clk; inputs change on the falling edge.
*/
`timescale 1ns/1ps
module flash_bus_command_interface_tb_top;
    localparam logic [7:0] MAKER = 8'h3C;
    localparam logic [7:0] PART = 8'hC5;
    logic sys_clk = 0, nrst = 0, clk_en = 1, powerdown_req = 0, req_valid = 0;
    logic req_ready, resp_valid, rp_n, ce_n, oe_n, we_n, data_pins_oe, flash_busy;
    logic ready_busy_out, dev_oe, vpp_high = 1;
    logic [7:0] resp_data, data_pins_out, dev_q, bus_last = 8'h00;
    wire logic [7:0] data_pins_in;
    logic [19:0] addr;
    fbc_pkg::fbc_req_t req = '0;
    int n_fail = 0, cmp_count = 0;
    always #5 sys_clk = ~sys_clk;
    fbc_host u_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
        .powerdown_req(powerdown_req), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .resp_valid(resp_valid), .resp_data(resp_data),
        .reset_powerdown_n(rp_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
        .data_pins_in(data_pins_in), .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe), .ready_busy_out(ready_busy_out),
        .flash_busy(flash_busy));
    fbc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (.sys_clk(sys_clk),
        .reset_powerdown_n(rp_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
        .dq_in(data_pins_out), .vpp_high(vpp_high), .dq_out(dev_q), .dq_drive(dev_oe),
        .ready_busy_out(ready_busy_out));
    // floating bus shows the inverse of the last level
    assign data_pins_in = dev_oe ? dev_q : (data_pins_oe ? data_pins_out : ~bus_last);
    always @(posedge sys_clk) bus_last <= data_pins_in;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task stop_test;
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // pin discipline while reading and writing
    always @(negedge sys_clk) begin
        if (nrst && !oe_n) chk({we_n, ce_n, rp_n, data_pins_oe}, 4'hA);
        if (nrst && !we_n) chk({ce_n, oe_n}, 2'h1);
    end
    task wait_ready;
        int i, n;
        i = 0; n = 0;
        while (req_ready !== 1'b1 && i < 1000) begin
            @(negedge sys_clk); i++;
            if (rp_n === 1'b1) n++;
        end
        chk(n >= fbc_pkg::WAKE_WRITE_CYC && i < 1000, 1);
    endtask
    task do_op(input fbc_pkg::fbc_op_t op, input logic [19:0] a, input logic [7:0] d);
        int i;
        @(negedge sys_clk);
        req_valid = 1; req = '{op, a, d}; i = 0;
        while (req_ready !== 1'b1 && i < 500) begin @(negedge sys_clk); i++; end
        @(negedge sys_clk);
        req_valid = 0; i = 0;
        while (resp_valid !== 1'b1 && i < 500) begin @(negedge sys_clk); i++; end
        chk(i < 500, 1);
    endtask
    task pd_cycle;
        @(negedge sys_clk);
        powerdown_req = 1;
        repeat (6) @(negedge sys_clk);
        chk({rp_n, dev_oe, ready_busy_out}, 3'h1);
        powerdown_req = 0;
        wait_ready();
    endtask
    task wait_job;
        int i;
        i = 0;
        while (flash_busy !== 1'b1 && i < 100) begin @(negedge sys_clk); i++; end
        chk(flash_busy, 1);
        while (flash_busy !== 1'b0 && i < 900) begin @(negedge sys_clk); i++; end
        chk(i < 900, 1);
    endtask
    task t_read_array;
        do_op(fbc_pkg::FBC_OP_READ, 20'h2_00A5, 8'h00);
        chk(resp_data, 8'hA5);
    endtask
    task t_ident;
        do_op(fbc_pkg::FBC_OP_READ_ID, fbc_pkg::ID_MAKER_ADDR, 8'h00);
        chk(resp_data, MAKER);
        do_op(fbc_pkg::FBC_OP_READ_ID, fbc_pkg::ID_PART_ADDR, 8'h00);
        chk(resp_data, PART);
        do_op(fbc_pkg::FBC_OP_READ_STATUS, 20'h0_0000, 8'h00);
        chk(resp_data, 8'h80);
    endtask
    task t_write;
        do_op(fbc_pkg::FBC_OP_BYTE_WRITE, 20'h1_0203, 8'h3C);
        wait_job();
        do_op(fbc_pkg::FBC_OP_READ_STATUS, 20'h1_0203, 8'h00);
        chk(resp_data, 8'h80);
        do_op(fbc_pkg::FBC_OP_READ, 20'h1_0203, 8'h00);
        chk(resp_data, 8'h3C);
    endtask
    task t_erase;
        do_op(fbc_pkg::FBC_OP_ERASE, 20'h3_1234, 8'h00);
        wait_job();
        pd_cycle();
        do_op(fbc_pkg::FBC_OP_READ, 20'h3_0010, 8'h00);
        chk(resp_data, 8'hFF);
    endtask
    task t_abort;
        int i;
        do_op(fbc_pkg::FBC_OP_ERASE, 20'h5_0042, 8'h00);
        i = 0;
        while (flash_busy !== 1'b1 && i < 100) begin @(negedge sys_clk); i++; end
        pd_cycle();
        chk(flash_busy, 0);
        do_op(fbc_pkg::FBC_OP_READ, 20'h5_0042, 8'h00);
        chk(resp_data, 8'h42);
    endtask
    task t_low_supply;
        vpp_high = 0;
        do_op(fbc_pkg::FBC_OP_BYTE_WRITE, 20'h7_0011, 8'h5A);
        do_op(fbc_pkg::FBC_OP_READ_STATUS, 20'h7_0011, 8'h00);
        chk(resp_data, 8'h88);
        do_op(fbc_pkg::FBC_OP_CLEAR_STATUS, 20'h0_0000, 8'h00);
        do_op(fbc_pkg::FBC_OP_READ_STATUS, 20'h0_0000, 8'h00);
        chk(resp_data, 8'h80);
        do_op(fbc_pkg::FBC_OP_BYTE_WRITE, 20'h7_0011, 8'h5A);
        do_op(fbc_pkg::FBC_OP_READ_ID, fbc_pkg::ID_PART_ADDR, 8'h00);
        chk(resp_data, PART);
        pd_cycle();
        do_op(fbc_pkg::FBC_OP_READ_STATUS, 20'h0_0000, 8'h00);
        chk(resp_data, 8'h80);
        pd_cycle();
        do_op(fbc_pkg::FBC_OP_READ, 20'h7_0011, 8'h00);
        chk(resp_data, 8'h11);
        vpp_high = 1;
    endtask
    task t_suspend;
        int i;
        do_op(fbc_pkg::FBC_OP_ERASE, 20'h6_0000, 8'h00);
        i = 0;
        while (flash_busy !== 1'b1 && i < 100) begin @(negedge sys_clk); i++; end
        do_op(fbc_pkg::FBC_OP_SUSPEND, 20'h6_0000, 8'h00);
        repeat (4) @(negedge sys_clk);
        chk(flash_busy, 0);
        do_op(fbc_pkg::FBC_OP_READ, 20'h1_0203, 8'h00);
        chk(resp_data, 8'h3C);
        do_op(fbc_pkg::FBC_OP_RESUME, 20'h6_0000, 8'h00);
        wait_job();
        do_op(fbc_pkg::FBC_OP_READ, 20'h6_0010, 8'h00);
        chk(resp_data, 8'hFF);
    endtask
    initial begin
        #300_000;
        n_fail++;
        stop_test();
    end
    initial begin
        repeat (2) @(negedge sys_clk);
        nrst = 1;
        wait_ready();
        t_read_array();
        t_ident();
        t_write();
        t_erase();
        t_suspend();
        t_abort();
        t_low_supply();
        stop_test();
    end
endmodule
